/* File: rtl/amw_host.sv */
// host controller driving write and read cycles on the asynchronous ram pins
`timescale 1ns/10ps
module amw_host #(
  parameter int ADDR_W = amw_pkg::ADDR_W,
  parameter int DATA_W = amw_pkg::DATA_W
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire amw_pkg::amw_req_t req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output amw_pkg::amw_pins_t     pins,
  input  wire logic [7:0]        low_data_lane_in,
  input  wire logic [7:0]        high_data_lane_in,
  output logic [7:0]             low_data_lane_out,
  output logic [7:0]             high_data_lane_out,
  output logic [1:0]             data_lane_oe
);

  // ****************************************************************
  // pin input synchroniser, three stages, change on stages two and three
  // ****************************************************************
  logic [DATA_W-1:0] sync1;
  logic [DATA_W-1:0] sync2;
  logic [DATA_W-1:0] sync3;
  logic [DATA_W-1:0] din_stable;
  logic [DATA_W-1:0] next_din_stable;

  always_comb
  begin
    next_din_stable = din_stable;
    if (sync2 == sync3)
    begin
      next_din_stable = sync3;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1      <= '0;
      sync2      <= '0;
      sync3      <= '0;
      din_stable <= '0;
    end
    else
    begin
      sync1      <= {high_data_lane_in, low_data_lane_in};
      sync2      <= sync1;
      sync3      <= sync2;
      din_stable <= next_din_stable;
    end
  end

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  amw_pkg::amw_state_t         state;
  amw_pkg::amw_state_t         next_state;
  logic [amw_pkg::CNT_W-1:0]   cnt;
  logic [amw_pkg::CNT_W-1:0]   next_cnt;
  logic [amw_pkg::CNT_W-1:0]   cyc_cnt;
  logic [amw_pkg::CNT_W-1:0]   next_cyc_cnt;
  amw_pkg::amw_pins_t          next_pins;
  logic [7:0]                  next_low_out;
  logic [7:0]                  next_high_out;
  logic [1:0]                  next_oe;
  logic                        next_ready;
  logic                        next_rsp_valid;
  logic [DATA_W-1:0]           next_rdata;

  // latched lane request from the accepted command
  logic [1:0] lane_en;
  logic [1:0] next_lane_en;

  function automatic logic req_lane(input logic hi);
    return hi ? lane_en[1] : lane_en[0];
  endfunction : req_lane

  // long enough for the worst of pulse, address-to-end and data-to-end
  localparam int PULSE_MIN = (amw_pkg::CYC_WPULSE > amw_pkg::CYC_ADDREND) ?
                             amw_pkg::CYC_WPULSE : amw_pkg::CYC_ADDREND;
  localparam int PULSE_CYC = (PULSE_MIN > amw_pkg::CYC_DATAEND) ?
                             PULSE_MIN : amw_pkg::CYC_DATAEND;
  // read waits past sync latency so sampled data is settled
  localparam int READ_CYC  = amw_pkg::CYC_CYCLE + 4;
  localparam int HOLD_CYC  = (amw_pkg::CYC_RECOVER > amw_pkg::CYC_HIGH) ?
                             amw_pkg::CYC_RECOVER : amw_pkg::CYC_HIGH;

  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_cyc_cnt   = cyc_cnt;
    next_pins      = pins;
    next_low_out   = low_data_lane_out;
    next_high_out  = high_data_lane_out;
    next_oe        = data_lane_oe;
    next_ready     = 1'b0;
    next_rsp_valid = 1'b0;
    next_rdata     = rsp_rdata;
    if (cyc_cnt != '0)
    begin
      next_cyc_cnt = cyc_cnt - 1'b1;
    end
    case (state)
      amw_pkg::AMW_IDLE:
      begin
        next_pins.chip_en_n          = amw_pkg::RST_CTRL_N;
        next_pins.write_en_n         = amw_pkg::RST_CTRL_N;
        next_pins.out_en_n           = amw_pkg::RST_CTRL_N;
        next_pins.low_lane_select_n  = amw_pkg::RST_LANE_N[0];
        next_pins.high_lane_select_n = amw_pkg::RST_LANE_N[1];
        next_oe                      = 2'h0;
        next_ready                   = 1'b1;
        if (req_valid && req_ready)
        begin
          next_ready     = 1'b0;
          next_pins.addr = req.addr;
          next_cyc_cnt   = amw_pkg::CNT_W'(amw_pkg::CYC_CYCLE);
          if (req.write)
          begin
            next_low_out  = req.wdata[7:0];
            next_high_out = req.wdata[15:8];
            next_state    = amw_pkg::AMW_SETUP;
          end
          else
          begin
            // write enable stays high through reads
            next_pins.write_en_n = 1'b1;
            next_pins.chip_en_n  = 1'b0;
            next_pins.out_en_n   = 1'b0;
            next_pins.low_lane_select_n  = 1'b0;
            next_pins.high_lane_select_n = 1'b0;
            next_cnt   = amw_pkg::CNT_W'(READ_CYC);
            next_state = amw_pkg::AMW_READ;
          end
        end
      end
      amw_pkg::AMW_SETUP:
      begin
        // output enable stays high so the device keeps its pins off the bus
        next_pins.out_en_n   = 1'b1;
        // chip enable, write enable and the requested lane selects fall on one edge: no byte select skew
        next_pins.chip_en_n  = 1'b0;
        next_pins.write_en_n = 1'b0;
        next_pins.low_lane_select_n  = ~req_lane(1'b0);
        next_pins.high_lane_select_n = ~req_lane(1'b1);
        next_oe    = 2'h3;
        next_cnt   = amw_pkg::CNT_W'(PULSE_CYC);
        next_state = amw_pkg::AMW_PULSE;
      end
      amw_pkg::AMW_PULSE:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == amw_pkg::CNT_W'(1))
        begin
          // end of write: write enable, chip enable and selects rise together
          next_pins.write_en_n         = 1'b1;
          next_pins.chip_en_n          = 1'b1;
          next_pins.low_lane_select_n  = 1'b1;
          next_pins.high_lane_select_n = 1'b1;
          next_cnt   = amw_pkg::CNT_W'(HOLD_CYC);
          next_state = amw_pkg::AMW_RECOV;
        end
      end
      amw_pkg::AMW_RECOV:
      begin
        // data and address held past the ending edge; strobes stay high
        next_oe  = 2'h0;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        if (cnt <= amw_pkg::CNT_W'(1) && cyc_cnt <= amw_pkg::CNT_W'(1))
        begin
          next_state = amw_pkg::AMW_IDLE;
        end
      end
      amw_pkg::AMW_READ:
      begin
        next_cnt = cnt - 1'b1;
        if (cnt == amw_pkg::CNT_W'(1))
        begin
          next_rdata     = din_stable;
          next_rsp_valid = 1'b1;
          next_pins.chip_en_n = 1'b1;
          next_pins.out_en_n  = 1'b1;
          next_pins.low_lane_select_n  = 1'b1;
          next_pins.high_lane_select_n = 1'b1;
          next_state     = amw_pkg::AMW_IDLE;
        end
      end
      default:
      begin
        next_state = amw_pkg::AMW_IDLE;
      end
    endcase
  end

  always_comb
  begin
    next_lane_en = lane_en;
    if (state == amw_pkg::AMW_IDLE && req_valid && req_ready)
    begin
      next_lane_en = req.lane_en;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state                   <= amw_pkg::AMW_IDLE;
      cnt                     <= '0;
      cyc_cnt                 <= '0;
      lane_en                 <= 2'h0;
      pins.addr               <= '0;
      pins.chip_en_n          <= amw_pkg::RST_CTRL_N;
      pins.write_en_n         <= amw_pkg::RST_CTRL_N;
      pins.out_en_n           <= amw_pkg::RST_CTRL_N;
      pins.low_lane_select_n  <= amw_pkg::RST_LANE_N[0];
      pins.high_lane_select_n <= amw_pkg::RST_LANE_N[1];
      low_data_lane_out       <= 8'h00;
      high_data_lane_out      <= 8'h00;
      data_lane_oe            <= 2'h0;
      req_ready               <= 1'b0;
      rsp_valid               <= 1'b0;
      rsp_rdata               <= '0;
    end
    else
    begin
      state              <= next_state;
      cnt                <= next_cnt;
      cyc_cnt            <= next_cyc_cnt;
      lane_en            <= next_lane_en;
      pins               <= next_pins;
      low_data_lane_out  <= next_low_out;
      high_data_lane_out <= next_high_out;
      data_lane_oe       <= next_oe;
      req_ready          <= next_ready;
      rsp_valid          <= next_rsp_valid;
      rsp_rdata          <= next_rdata;
    end
  end

endmodule : amw_host

/* File: rtl/amw_pkg.sv */
// package for the asynchronous nonvolatile ram write-cycle host controller
package amw_pkg;

  // ****************************************************************
  // widths and clock
  // ****************************************************************
  localparam int ADDR_W      = 18;
  localparam int DATA_W      = 16;
  localparam int CLK_PERIOD_NS = 100;

  // ****************************************************************
  // timing figures in ns (slowest speed grade)
  // ****************************************************************
  localparam int T_CYCLE_NS    = 35;
  localparam int T_WPULSE_NS   = 15;
  localparam int T_ADDR_END_NS = 20;
  localparam int T_DATA_END_NS = 10;
  localparam int T_RECOVER_NS  = 12;
  localparam int T_HIGH_NS     = 2;
  localparam int T_WLQZ_NS     = 12;

  // least times round up to whole cycles, never below one
  function automatic int amw_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : amw_cyc

  localparam int CYC_CYCLE   = amw_cyc(T_CYCLE_NS);
  localparam int CYC_WPULSE  = amw_cyc(T_WPULSE_NS);
  localparam int CYC_ADDREND = amw_cyc(T_ADDR_END_NS);
  localparam int CYC_DATAEND = amw_cyc(T_DATA_END_NS);
  localparam int CYC_RECOVER = amw_cyc(T_RECOVER_NS);
  localparam int CYC_HIGH    = amw_cyc(T_HIGH_NS);
  localparam int CYC_WLQZ    = amw_cyc(T_WLQZ_NS);
  localparam int CNT_W       = 4;

  // ****************************************************************
  // reset values of the pin drivers
  // ****************************************************************
  localparam logic       RST_CTRL_N = 1'b1;
  localparam logic [1:0] RST_LANE_N = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [4:0] {
    AMW_IDLE   = 5'h01,
    AMW_SETUP  = 5'h02,
    AMW_PULSE  = 5'h04,
    AMW_RECOV  = 5'h08,
    AMW_READ   = 5'h10
  } amw_state_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lane_en;
  } amw_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_en_n;
    logic              write_en_n;
    logic              out_en_n;
    logic              low_lane_select_n;
    logic              high_lane_select_n;
  } amw_pins_t;

endpackage : amw_pkg

/* File: dv/amw_chk.sv */
// assertions on the ram host controller's pins and handshake
`timescale 1ns/10ps
module amw_chk (
  input wire logic               ref_clk,
  input wire logic               arst_n,
  input wire amw_pkg::amw_req_t  req,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire logic               rsp_valid,
  input wire amw_pkg::amw_pins_t pins,
  input wire logic [7:0]         low_data_lane_out,
  input wire logic [7:0]         high_data_lane_out,
  input wire logic [1:0]         data_lane_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_overlap; !pins.write_en_n |-> !pins.chip_en_n && pins.out_en_n; endproperty
  a_overlap: assert property (p_overlap) else $error("write strobe outside chip enable");
  property p_end_all;
    $rose(pins.write_en_n) |-> pins.chip_en_n && pins.low_lane_select_n && pins.high_lane_select_n;
  endproperty
  a_end_all: assert property (p_end_all) else $error("strobes not ended together");
  property p_pulse; $fell(pins.write_en_n) |-> ##[1:4] $rose(pins.write_en_n); endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse never ends");
  property p_skew;
    $fell(pins.low_lane_select_n) && !pins.high_lane_select_n |-> $fell(pins.high_lane_select_n);
  endproperty
  a_skew: assert property (p_skew) else $error("lane selects skewed");
  property p_data;
    $rose(pins.write_en_n) |-> data_lane_oe == 2'h3 && $stable(low_data_lane_out)
      && $stable(high_data_lane_out);
  endproperty
  a_data: assert property (p_data) else $error("write data not held to end");
  property p_addr_set; $fell(pins.write_en_n) |-> $stable(pins.addr); endproperty
  a_addr_set: assert property (p_addr_set) else $error("address late for write");
  property p_addr_hold;
    $rose(pins.write_en_n) |-> $stable(pins.addr) ##1 $stable(pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address left in recovery");
  // take, setup, pulse, recovery, idle: ready is back on the fifth edge
  property p_wr_ready;
    req_valid && req_ready && req.write |=> !req_ready[*4] ##1 req_ready;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write cycle length wrong");
  property p_rd_rsp; req_valid && req_ready && !req.write |-> ##[6:8] rsp_valid; endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("read answer missing");
endmodule : amw_chk

bind amw_host amw_chk amw_chk_i (.ref_clk, .arst_n, .req, .req_valid, .req_ready, .rsp_valid,
  .pins, .low_data_lane_out, .high_data_lane_out, .data_lane_oe);

/* File: dv/amw_dev_model.sv */
// behavioural model of the byte-laned nonvolatile ram
`timescale 1ns/10ps
module amw_dev_model (
  input wire amw_pkg::amw_pins_t pins,
  input wire logic [15:0]        dq_in,
  output logic [15:0]            dq_out
);
  logic [15:0] mem [0:255];
  wire         drive = !pins.chip_en_n && !pins.out_en_n && pins.write_en_n;
  initial dq_out = 16'h0000;
  always @(pins or dq_in)
    if (!pins.chip_en_n && !pins.write_en_n)
    begin
      if (!pins.low_lane_select_n) mem[pins.addr[7:0]][7:0] = dq_in[7:0];
      if (!pins.high_lane_select_n) mem[pins.addr[7:0]][15:8] = dq_in[15:8];
    end
  // released lines flip, so a stale value never looks valid
  always @(pins)
    if (drive) #3 dq_out = mem[pins.addr[7:0]];
    else dq_out = ~dq_out;
endmodule : amw_dev_model

/* File: dv/amw_host_bench.sv */
// self-checking bench for the ram write-cycle host controller
`timescale 1ns/10ps
module amw_host_bench;
  typedef struct {
    amw_pkg::amw_req_t rq;
    logic [15:0]       exp;
  } amw_row_t;
  logic               ref_clk;
  logic               arst_n;
  amw_pkg::amw_req_t  req;
  logic               req_valid;
  logic               req_ready;
  logic               rsp_valid;
  logic [15:0]        rsp_rdata;
  amw_pkg::amw_pins_t pins;
  logic [7:0]         low_out;
  logic [7:0]         high_out;
  logic [1:0]         data_lane_oe;
  logic [15:0]        dev_q;
  wire  [15:0]        dq = {data_lane_oe[1] ? high_out : dev_q[15:8],
                            data_lane_oe[0] ? low_out : dev_q[7:0]};
  int                 miscompares = 0;
  int                 samples_checked = 0;
  amw_row_t           rows [7] = '{
    '{{1'b1, 18'h00010, 16'h1234, 2'h3}, 16'h0000},
    '{{1'b1, 18'h00010, 16'hABCD, 2'h1}, 16'h0000},
    '{{1'b1, 18'h00010, 16'h5678, 2'h2}, 16'h0000},
    '{{1'b1, 18'h00010, 16'hFFFF, 2'h0}, 16'h0000},
    '{{1'b0, 18'h00010, 16'h0000, 2'h0}, 16'h56CD},
    '{{1'b1, 18'h3FFFF, 16'hA55A, 2'h3}, 16'h0000},
    '{{1'b0, 18'h3FFFF, 16'h0000, 2'h0}, 16'hA55A}};

  amw_host amw_host_i (.ref_clk(ref_clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
    .low_data_lane_in(dq[7:0]), .high_data_lane_in(dq[15:8]), .low_data_lane_out(low_out),
    .high_data_lane_out(high_out), .data_lane_oe(data_lane_oe));
  amw_dev_model amw_dev_model_i (.pins(pins), .dq_in(dq), .dq_out(dev_q));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // entered and left on a falling edge
  task automatic do_op(input amw_row_t r);
    // one falling edge after the previous call returns
    @(negedge ref_clk);
    req = r.rq;
    req_valid = 1'b1;
    for (int n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    chk("request taken", 16'h0001, {15'h0000, req_ready});
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (!r.rq.write)
    begin
      for (int n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
      chk("read done", 16'h0001, {15'h0000, rsp_valid});
      chk("read data", r.exp, rsp_rdata);
    end
  endtask : do_op

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // about 60 cycles expected; 2000 allowed
  initial
  begin
    #200000;
    miscompares++;
    end_sim();
  end

  initial
  begin
    arst_n = 1'b0;
    req = '0;
    req_valid = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("ready in reset", 16'h0000, {15'h0000, req_ready});
    chk("write enable in reset", 16'h0001, {15'h0000, pins.write_en_n});
    arst_n = 1'b1;
    $display("reset test done");
    foreach (rows[k]) do_op(rows[k]);
    $display("row tests done");
    // reset lands inside the write pulse: strobes drop, the overlap already stored
    req = {1'b1, 18'h00010, 16'h0BAD, 2'h3};
    req_valid = 1'b1;
    for (int n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    chk("write enable in pulse", 16'h0000, {15'h0000, pins.write_en_n});
    arst_n = 1'b0;
    req_valid = 1'b0;
    #10;
    chk("chip enable in reset", 16'h0001, {15'h0000, pins.chip_en_n});
    chk("lane drive in reset", 16'h0000, {14'h0000, data_lane_oe});
    @(negedge ref_clk);
    arst_n = 1'b1;
    do_op('{{1'b0, 18'h00010, 16'h0000, 2'h0}, 16'h0BAD});
    $display("reset in mid-write test done");
    end_sim();
  end
endmodule : amw_host_bench
